// ==== design/dceac_pkg.sv ====
// constants, register map and types shared by the dma channel control design
package dceac_pkg;
  localparam int ADDR_W = 24;
  localparam int CNT_W  = 16;
  localparam int NCH    = 2;
  localparam int NSUB   = 4;
  // register byte offsets
  localparam logic [7:0] OFS_BAND    = 8'h00;
  localparam logic [2:0] CH_SLOT0    = 3'h1;
  localparam logic [4:0] OFS_SRC     = 5'h00;
  localparam logic [4:0] OFS_DST     = 5'h04;
  localparam logic [4:0] OFS_CNTA    = 5'h08;
  localparam logic [4:0] OFS_CNTB    = 5'h0C;
  localparam logic [4:0] OFS_MODE    = 5'h10;
  // band control field positions
  localparam int BIT_IRQEN  = 0;
  localparam int BIT_XFEREN = 4;
  localparam int BIT_ACKCLR = 8;
  localparam int BIT_SINGLE = 12;
  localparam int BIT_FULL   = 14;
  localparam logic [15:0] BAND_RST = 16'h0000;
  // mode register field positions
  localparam int MODE_W    = 6;
  localparam int M_WORD    = 0;
  localparam int M_SRCSTEP = 1;
  localparam int M_SRCDEC  = 2;
  localparam int M_DSTSTEP = 3;
  localparam int M_DSTDEC  = 4;
  localparam int M_BLOCK   = 5;
  localparam logic [MODE_W-1:0] MODE_RST = 6'h00;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;
  localparam logic [7:0]  BLK_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

  typedef logic [ADDR_W-1:0] dceac_addr_t;
  typedef logic [CNT_W-1:0]  dceac_cnt_t;
  typedef enum logic [1:0] {ENG_IDLE, ENG_REQ, ENG_GAP} dceac_eng_state_t;

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] dceac_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b]) r[8*b +: 8] = wd[8*b +: 8];
    return r;
  endfunction
endpackage

// ==== design/dceac_eng_if.sv ====
// link between the control top and one full-address transfer engine
`timescale 1ns/1ps
interface dceac_eng_if;
  import dceac_pkg::*;
  logic                 wrSrc, wrDst, wrCntA, wrCntB, wrMode;
  logic [31:0]          wrData;
  logic [3:0]           wrSel;
  logic                 run;
  logic                 act;
  logic                 xferAck;
  logic                 xferReq;
  logic                 doneP;
  logic                 ackP;
  dceac_addr_t          srcAddr, dstAddr;
  dceac_cnt_t           cntA, cntB;
  logic [MODE_W-1:0]    mode;
  modport ctl (output wrSrc, wrDst, wrCntA, wrCntB, wrMode, wrData, wrSel, run, act, xferAck,
               input xferReq, doneP, ackP, srcAddr, dstAddr, cntA, cntB, mode);
  modport eng (input wrSrc, wrDst, wrCntA, wrCntB, wrMode, wrData, wrSel, run, act, xferAck,
               output xferReq, doneP, ackP, srcAddr, dstAddr, cntA, cntB, mode);
endinterface

// ==== design/dceac_xfer_engine.sv ====
// one full-address channel: address stepping, transfer counting, request handshake
`timescale 1ns/1ps
module dceac_xfer_engine
(
  input  wire logic   sys_clk,
  input  wire logic   rstSyncN,
  input  wire logic   clkEn,
  dceac_eng_if.eng    eng
);
  import dceac_pkg::*;

  dceac_eng_state_t  state_reg, state_next;
  dceac_addr_t       src_reg, src_next, dst_reg, dst_next;
  dceac_cnt_t        cntA_reg, cntA_next, cntB_reg, cntB_next;
  logic [MODE_W-1:0] mode_reg, mode_next;
  logic              done_reg, done_next, ack_reg, ack_next;
  dceac_addr_t       step;
  logic [7:0]        blkLow;
  logic [31:0]       srcMrg, dstMrg, cntAMrg, cntBMrg, modeMrg;

  // byte-lane merges of a software write into each register
  assign srcMrg  = dceac_merge({8'h00, src_reg}, eng.wrData, eng.wrSel);
  assign dstMrg  = dceac_merge({8'h00, dst_reg}, eng.wrData, eng.wrSel);
  assign cntAMrg = dceac_merge({16'h0000, cntA_reg}, eng.wrData, eng.wrSel);
  assign cntBMrg = dceac_merge({16'h0000, cntB_reg}, eng.wrData, eng.wrSel);
  assign modeMrg = dceac_merge({26'h0, mode_reg}, eng.wrData, eng.wrSel);

  // next state of sequencer, addresses and counters
  always_comb
  begin
    state_next = state_reg;
    src_next   = src_reg;
    dst_next   = dst_reg;
    cntA_next  = cntA_reg;
    cntB_next  = cntB_reg;
    mode_next  = mode_reg;
    done_next  = 1'b0;
    ack_next   = 1'b0;
    step       = mode_reg[M_WORD] ? STEP_WORD : STEP_BYTE;
    blkLow     = cntA_reg[7:0] - 8'h01;
    unique case (state_reg)
      ENG_IDLE:
        if (eng.run && eng.act) state_next = ENG_REQ;
      ENG_REQ:
        if (!eng.run) state_next = ENG_IDLE;  // aborted
        else if (eng.xferAck)
        begin
          state_next = ENG_GAP;
          ack_next   = 1'b1;
          if (mode_reg[M_SRCSTEP])
            src_next = mode_reg[M_SRCDEC] ? src_reg - step : src_reg + step;
          if (mode_reg[M_DSTSTEP])
            dst_next = mode_reg[M_DSTDEC] ? dst_reg - step : dst_reg + step;
          if (!mode_reg[M_BLOCK])
          begin
            cntA_next = cntA_reg - CNT_ONE;
            done_next = (cntA_next == CNT_ZERO);
          end
          else if (blkLow == BLK_ZERO)
          begin
            cntA_next = {cntA_reg[15:8], cntA_reg[15:8]};
            cntB_next = cntB_reg - CNT_ONE;
            done_next = (cntB_next == CNT_ZERO);
          end
          else
            cntA_next = {cntA_reg[15:8], blkLow};
        end
      ENG_GAP:
        state_next = ENG_IDLE;  // lets the cleared source drop
    endcase
    // software loads, upper address byte ignored
    if (eng.wrSrc) src_next = srcMrg[ADDR_W-1:0];
    if (eng.wrDst) dst_next = dstMrg[ADDR_W-1:0];
    if (eng.wrCntA) cntA_next = cntAMrg[CNT_W-1:0];
    if (eng.wrCntB) cntB_next = cntBMrg[CNT_W-1:0];
    if (eng.wrMode) mode_next = modeMrg[MODE_W-1:0];
  end

  // control state with reset
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state_reg <= ENG_IDLE;
      mode_reg  <= MODE_RST;
      done_reg  <= 1'b0;
      ack_reg   <= 1'b0;
    end
    else if (clkEn)
    begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      done_reg  <= done_next;
      ack_reg   <= ack_next;
    end
  end

  // address and count registers are not reset
  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      src_reg  <= src_next;
      dst_reg  <= dst_next;
      cntA_reg <= cntA_next;
      cntB_reg <= cntB_next;
    end
  end

  // source from A side, destination from B side
  assign eng.xferReq = (state_reg == ENG_REQ);
  assign eng.doneP   = done_reg;
  assign eng.ackP    = ack_reg;
  assign eng.srcAddr = src_reg;
  assign eng.dstAddr = dst_reg;
  assign eng.cntA    = cntA_reg;
  assign eng.cntB    = cntB_reg;
  assign eng.mode    = mode_reg;
endmodule

// ==== design/dceac_top.sv ====
// dma channel enable, acknowledge and full-address control with wishbone registers
`timescale 1ns/1ps
// Overview of operation
// - ack-clear bits 11 to 8, bits 8 and 10 clear source on transfer
// - disabled channel ignores source, request passes on
// - irq enable with transfer off raises end irq
// - enable cleared by reset, completion, or write 0
// - enable sets only on write after read zero
// - enabled A-side channel transfers on each source request in full address mode
// - transfer enables at bits 7 to 4
// - end irq enables at bits 3 to 0
// - full address mode runs A and B together
// - 24-bit address, A source, B destination
// - top eight address bits read zero, ignore writes
// - addresses step after each transfer
// - address registers not reset
// - io address unused in full address mode
// - 16-bit count, normal or block function
// - count register not reset
// - ack-clear with enable hides source from cpu
// - normal mode counts down to zero
// - block mode reloads low byte, counts blocks
// - step one for byte, two for word
module dceac_top
(
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  input  wire logic                          clkEn,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [dceac_pkg::NSUB-1:0]    actReq,
  output logic      [dceac_pkg::NSUB-1:0]    srcIrq,
  output logic      [dceac_pkg::NSUB-1:0]    srcClear,
  output logic      [dceac_pkg::NSUB-1:0]    endIrq,
  output logic      [dceac_pkg::NCH-1:0]     xferReq,
  input  wire logic [dceac_pkg::NCH-1:0]     xferAck,
  output dceac_pkg::dceac_addr_t             xferSrc [dceac_pkg::NCH],
  output dceac_pkg::dceac_addr_t             xferDst [dceac_pkg::NCH],
  output logic      [dceac_pkg::NCH-1:0]     xferWord
);
  import dceac_pkg::*;

  logic              rstMeta, rstSyncN;
  logic [15:0]       band_reg, band_next;
  logic [NSUB-1:0]   readZero_reg, readZero_next;
  logic              ack_reg, ack_next;
  logic [31:0]       rdat_reg, rdat_next;
  logic [NSUB-1:0]   srcIrq_reg, srcIrq_next;
  logic [NSUB-1:0]   srcClr_reg, srcClr_next;
  logic [NSUB-1:0]   endIrq_reg, endIrq_next;
  logic              take, wrTake, rdTake, selBand;
  logic [2:0]        slot;
  logic [4:0]        regOfs;
  logic [NSUB-1:0]   xferEn, irqEn, ackClr, wrEn;
  logic [NCH-1:0]    fullMode, chDone, chAck, chSel;
  dceac_addr_t       chSrc [NCH];
  dceac_addr_t       chDst [NCH];
  dceac_cnt_t        chCntA [NCH];
  dceac_cnt_t        chCntB [NCH];
  logic [MODE_W-1:0] chMode [NCH];

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // bus decode, one access taken per request
  assign take    = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wrTake  = take && wb_we_i;
  assign rdTake  = take && !wb_we_i;
  assign slot    = wb_adr_i[7:5];
  assign regOfs  = wb_adr_i[4:0];
  assign selBand = (wb_adr_i == OFS_BAND);

  // band control field views
  assign xferEn   = band_reg[BIT_XFEREN +: NSUB];
  assign irqEn    = band_reg[BIT_IRQEN +: NSUB];
  assign ackClr   = band_reg[BIT_ACKCLR +: NSUB];
  assign fullMode = band_reg[BIT_FULL +: NCH];
  assign wrEn     = wb_dat_i[BIT_XFEREN +: NSUB];

  // one engine per channel, A and B paired
  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      dceac_eng_if eng ();
      assign chSel[c]     = (slot == CH_SLOT0 + 3'(c));
      assign eng.wrData   = wb_dat_i;
      assign eng.wrSel    = wb_sel_i;
      assign eng.wrSrc    = wrTake && chSel[c] && regOfs == OFS_SRC;
      assign eng.wrDst    = wrTake && chSel[c] && regOfs == OFS_DST;
      assign eng.wrCntA   = wrTake && chSel[c] && regOfs == OFS_CNTA;
      assign eng.wrCntB   = wrTake && chSel[c] && regOfs == OFS_CNTB;
      assign eng.wrMode   = wrTake && chSel[c] && regOfs == OFS_MODE;
      assign eng.run      = fullMode[c] && xferEn[2*c];
      assign eng.act      = actReq[2*c];
      assign eng.xferAck  = xferAck[c];
      assign xferReq[c]   = eng.xferReq;
      assign chDone[c]    = eng.doneP;
      assign chAck[c]     = eng.ackP;
      assign chSrc[c]     = eng.srcAddr;
      assign chDst[c]     = eng.dstAddr;
      assign chCntA[c]    = eng.cntA;
      assign chCntB[c]    = eng.cntB;
      assign chMode[c]    = eng.mode;
      assign xferSrc[c]   = eng.srcAddr;
      assign xferDst[c]   = eng.dstAddr;
      assign xferWord[c]  = eng.mode[M_WORD];
      dceac_xfer_engine u_eng
      (
        .sys_clk  (sys_clk),
        .rstSyncN (rstSyncN),
        .clkEn    (clkEn),
        .eng      (eng)
      );
    end
  endgenerate

  // band register, read data, source routing and end interrupts
  always_comb
  begin
    band_next     = band_reg;
    readZero_next = readZero_reg;
    ack_next      = take;
    rdat_next     = 32'h0000_0000;
    // completion clears both sub-channel enables
    for (int k = 0; k < NCH; k++)
      if (chDone[k])
      begin
        band_next[BIT_XFEREN + 2*k]     = 1'b0;
        band_next[BIT_XFEREN + 2*k + 1] = 1'b0;
      end
    if (wrTake && selBand)
    begin
      if (wb_sel_i[1]) band_next[15:8] = wb_dat_i[15:8];
      if (wb_sel_i[0])
      begin
        band_next[BIT_IRQEN +: NSUB] = wb_dat_i[BIT_IRQEN +: NSUB];
        // write 0 aborts, write 1 needs a prior zero read
        for (int k = 0; k < NSUB; k++)
          if (!wrEn[k]) band_next[BIT_XFEREN + k] = 1'b0;
          else if (readZero_reg[k]) band_next[BIT_XFEREN + k] = 1'b1;
        readZero_next = '0;
      end
    end
    if (rdTake && selBand)
    begin
      readZero_next = ~xferEn;  // arms the set
    end
    // readback mux, unmapped reads give zero
    if (rdTake)
    begin
      if (selBand)
        rdat_next = {16'h0000, band_reg};
      for (int k = 0; k < NCH; k++)
        if (chSel[k])
          unique case (regOfs)
            OFS_SRC:  rdat_next = {8'h00, chSrc[k]};
            OFS_DST:  rdat_next = {8'h00, chDst[k]};
            OFS_CNTA: rdat_next = {16'h0000, chCntA[k]};
            OFS_CNTB: rdat_next = {16'h0000, chCntB[k]};
            OFS_MODE: rdat_next = {26'h0, chMode[k]};
            default:  rdat_next = 32'h0000_0000;
          endcase
    end
    // request to cpu unless consumed by acked transfer
    srcIrq_next = actReq & ~(xferEn & ackClr);
    // end interrupt held while enabled and idle
    endIrq_next = irqEn & ~xferEn;
    // source clear pulse after each transfer
    srcClr_next = '0;
    for (int k = 0; k < NCH; k++)
      srcClr_next[2*k] = chAck[k] && ackClr[2*k];
  end

  // register the band group
  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      band_reg     <= BAND_RST;
      readZero_reg <= '0;
      ack_reg      <= 1'b0;
      rdat_reg     <= 32'h0000_0000;
      srcIrq_reg   <= '0;
      srcClr_reg   <= '0;
      endIrq_reg   <= '0;
    end
    else if (clkEn)
    begin
      band_reg     <= band_next;
      readZero_reg <= readZero_next;
      ack_reg      <= ack_next;
      rdat_reg     <= rdat_next;
      srcIrq_reg   <= srcIrq_next;
      srcClr_reg   <= srcClr_next;
      endIrq_reg   <= endIrq_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign srcIrq   = srcIrq_reg;
  assign srcClear = srcClr_reg;
  assign endIrq   = endIrq_reg;
endmodule

// ==== tb/dceac_top_monitor.sv ====
// concurrent checks on the dma channel control top ports
`timescale 1ns/1ps
module dceac_top_monitor
(
  input wire logic [0:0]         sys_clk,
  input wire logic [0:0]         rstn,
  input wire logic [0:0]         clkEn,
  input wire logic [0:0]         wb_cyc_i,
  input wire logic [0:0]         wb_stb_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic [0:0]         wb_ack_o,
  input wire logic [3:0]         actReq,
  input wire logic [3:0]         srcIrq,
  input wire logic [3:0]         srcClear,
  input wire logic [1:0]         xferReq,
  input wire logic [1:0]         xferAck,
  input dceac_pkg::dceac_addr_t  xferSrc [dceac_pkg::NCH],
  input wire logic [1:0]         xferWord
);
  import dceac_pkg::*;
  dceac_addr_t stepAmt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // step size that the current transfer width allows
  assign stepAmt = xferWord[0] ? STEP_WORD : STEP_BYTE;
  chk_bus_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus request not answered in one cycle");
  chk_addr_top:
    assert property (wb_ack_o && $past(wb_adr_i[7:5]) != 3'h0 && $past(wb_adr_i[4:3]) == 2'h0
      |-> wb_dat_o[31:24] == 8'h00) else $error("address top byte not zero");
  chk_src_pass:
    assert property (clkEn |=> (srcIrq & ~$past(actReq)) == 4'h0) else $error("source request without cause");
  chk_clear_side:
    assert property ((srcClear & 4'hA) == 4'h0) else $error("clear on b side");
  chk_clear_cause:
    assert property (srcClear[0] |-> $past(xferAck[0], 2) || $past(xferAck[0]))
    else $error("clear without transfer");
  chk_req_cause:
    assert property ($rose(xferReq[0]) |-> $past(actReq[0])) else $error("request without source");
  chk_req_hold:
    assert property (xferReq[0] && !xferAck[0] && !wb_stb_i && !wb_ack_o && !$past(wb_ack_o)
      |=> xferReq[0]) else $error("request dropped early");
  chk_req_gap:
    assert property (xferReq[0] && xferAck[0] |=> !xferReq[0] [*2]) else $error("request gap short");
  chk_addr_step:
    assert property (xferReq[0] && xferAck[0] |=> xferSrc[0] == $past(xferSrc[0])
      || xferSrc[0] == $past(xferSrc[0]) + stepAmt || xferSrc[0] == $past(xferSrc[0]) - stepAmt)
    else $error("bad address step");
  cov_xfer0: cover property (xferReq[0] && xferAck[0]);
  cov_clear: cover property (srcClear[0]);
  cov_xfer1: cover property (xferReq[1] && xferAck[1]);
endmodule
bind dceac_top dceac_top_monitor dceac_top_monitor_i
(
  .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .actReq(actReq), .srcIrq(srcIrq),
  .srcClear(srcClear), .xferReq(xferReq), .xferAck(xferAck), .xferSrc(xferSrc), .xferWord(xferWord)
);

// ==== tb/dceac_xfer_partner.sv ====
// far-side transfer responder: acknowledges each request after a stall
`timescale 1ns/1ps
module dceac_xfer_partner
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] waitCyc,
  input  wire logic [1:0] xferReq,
  output logic      [1:0] xferAck
);
  logic [7:0] waitCnt_reg [2];
  // per channel: stall waitCyc cycles, then a one-cycle acknowledge
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      xferAck        <= 2'b00;
      waitCnt_reg[0] <= 8'h00;
      waitCnt_reg[1] <= 8'h00;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (!xferReq[c] || xferAck[c])
        begin
          xferAck[c]     <= 1'b0;
          waitCnt_reg[c] <= 8'h00;
        end
        else
        begin
          xferAck[c]     <= (waitCnt_reg[c] >= waitCyc);
          waitCnt_reg[c] <= waitCnt_reg[c] + 8'h01;
        end
      end
    end
  end
endmodule

// ==== tb/tb_dceac_top.sv ====
// self-checking bench for the dma channel control top
`timescale 1ns/1ps
`define CHK(g, e) chk_val(32'(g), 32'(e))
module tb_dceac_top;
  import dceac_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        clkEn = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  actReq = 4'h0;
  logic [3:0]  srcIrq;
  logic [3:0]  srcClear;
  logic [3:0]  endIrq;
  logic [1:0]  xferReq;
  logic [1:0]  xferAck;
  dceac_addr_t xferSrc [NCH];
  dceac_addr_t xferDst [NCH];
  logic [1:0]  xferWord;
  logic [7:0]  waitCyc = 8'h00;
  logic [31:0] rd;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycCount = 0;
  int          ackCnt [2] = '{0, 0};
  int          clrCnt = 0;
  dceac_top dceac_top_i
  (
    .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .actReq(actReq), .srcIrq(srcIrq), .srcClear(srcClear),
    .endIrq(endIrq), .xferReq(xferReq), .xferAck(xferAck), .xferSrc(xferSrc), .xferDst(xferDst),
    .xferWord(xferWord)
  );
  dceac_xfer_partner dceac_xfer_partner_i
  (
    .sys_clk(sys_clk), .rstn(rstn), .waitCyc(waitCyc), .xferReq(xferReq), .xferAck(xferAck)
  );
  always #4 sys_clk = ~sys_clk;
  // hang ceiling and tallies of transfers and source clears
  always @(posedge sys_clk)
  begin
    cycCount++;
    if (xferAck[0] === 1'b1) ackCnt[0]++;
    if (xferAck[1] === 1'b1) ackCnt[1]++;
    if (srcClear[0] === 1'b1) clrCnt++;
    if (cycCount == 5000)
    begin
      num_errors++;
      test_done();
    end
  end
  // compare and count
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one classic wishbone cycle, entered just after a rising edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20) num_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h00000000);
    `CHK(rd, e);
  endtask
  task automatic wait_end(input int b);
    int n;
    n = 0;
    while (endIrq[b] !== 1'b1 && n < 500)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // reset values, unmapped place, set-after-read and abort
  task automatic t_regs();
    rchk(OFS_BAND, 32'h00000000);
    wb(8'hFC, 1'b1, 32'hFFFFFFFF);
    rchk(8'hFC, 32'h00000000);
    wb(OFS_BAND, 1'b1, 32'h00000000);
    wb(OFS_BAND, 1'b1, 32'h000000F0);
    rchk(OFS_BAND, 32'h00000000);
    wb(OFS_BAND, 1'b1, 32'h000000F0);
    rchk(OFS_BAND, 32'h000000F0);
    wb(OFS_BAND, 1'b1, 32'h00000000);
    rchk(OFS_BAND, 32'h00000000);
  endtask
  // end request follows each enable while transfer is off
  task automatic t_end_irq();
    for (int i = 0; i < 4; i++)
    begin
      wb(OFS_BAND, 1'b1, 32'(1 << i));
      repeat (2) @(posedge sys_clk);
      `CHK(endIrq, 1 << i);
    end
    repeat (20) @(posedge sys_clk);
    `CHK(endIrq, 4'h8);
    wb(OFS_BAND, 1'b1, 32'h00000000);
    repeat (2) @(posedge sys_clk);
    `CHK(endIrq, 4'h0);
    actReq <= 4'hF;
    repeat (3) @(posedge sys_clk);
    `CHK(srcIrq, 4'hF);
    // clock enable low freezes the registered source requests
    clkEn <= 1'b0;
    actReq <= 4'h0;
    repeat (3) @(posedge sys_clk);
    `CHK(srcIrq, 4'hF);
    clkEn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK(srcIrq, 4'h0);
  endtask
  // channel 0 full address, word, source up, destination down, slow far side
  task automatic t_full();
    wb(8'h20, 1'b1, 32'hFF001000);
    rchk(8'h20, 32'h00001000);
    wb(8'h24, 1'b1, 32'h00002000);
    wb(8'h28, 1'b1, 32'h00000002);
    wb(8'h30, 1'b1, 32'h0000001B);
    waitCyc <= 8'h03;
    wb(OFS_BAND, 1'b0, 32'h00000000);
    wb(OFS_BAND, 1'b1, 32'h00004111);
    actReq <= 4'h1;
    repeat (2) @(posedge sys_clk);
    `CHK(srcIrq, 4'h0);
    wait_end(0);
    `CHK(endIrq, 4'h1);
    `CHK(ackCnt[0], 2);
    `CHK(clrCnt, 2);
    `CHK(xferSrc[0], 24'h001004);
    `CHK(xferDst[0], 24'h001FFC);
    `CHK(xferWord[0], 1'b1);
    repeat (2) @(posedge sys_clk);
    `CHK(srcIrq, 4'h1);
    rchk(OFS_BAND, 32'h00004101);
    rchk(8'h28, 32'h00000000);
    actReq <= 4'h0;
  endtask
  // channel 1 block mode, byte, fixed addresses, prompt far side
  task automatic t_block();
    wb(8'h40, 1'b1, 32'h00123456);
    wb(8'h44, 1'b1, 32'h0000ABCD);
    wb(8'h48, 1'b1, 32'h00000202);
    wb(8'h4C, 1'b1, 32'h00000002);
    wb(8'h50, 1'b1, 32'h00000020);
    waitCyc <= 8'h00;
    wb(OFS_BAND, 1'b0, 32'h00000000);
    wb(OFS_BAND, 1'b1, 32'h00008044);
    actReq <= 4'h4;
    wait_end(2);
    `CHK(ackCnt[1], 4);
    `CHK(xferSrc[1], 24'h123456);
    `CHK(xferDst[1], 24'h00ABCD);
    rchk(8'h4C, 32'h00000000);
    rchk(OFS_BAND, 32'h00008004);
    actReq <= 4'h0;
  endtask
  // reset, then the scenarios in order
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_end_irq();
    t_full();
    t_block();
    test_done();
  end
endmodule
